// file: ddc_map.vh
// register map, field positions, reset values and timing for the drive port
// assumes a 100 MHz clock; included by every design file of the block
`ifndef DDC_MAP_VH
`define DDC_MAP_VH

// register byte offsets
`define DDC_A_CTRL   8'h00
`define DDC_A_CMD    8'h04
`define DDC_A_SEEK   8'h08
`define DDC_A_RWC    8'h0c
`define DDC_A_RETRY  8'h10
`define DDC_A_STAT   8'h14
`define DDC_A_CYL    8'h18

// control register fields
`define DDC_C_DRV    0
`define DDC_C_SELEN  1
`define DDC_C_HD8    2
`define DDC_C_FMT    3
`define DDC_C_HEAD   7:4
`define DDC_C_HMSB   7

// command register bits (write only, self clearing)
`define DDC_K_SEEK   0
`define DDC_K_WRON   1
`define DDC_K_WROFF  2
`define DDC_K_ABORT  3

// seek register fields
`define DDC_S_CNT    15:0
`define DDC_S_DIR    16

// status register bits
`define DDC_T_BUSY   0
`define DDC_T_SEEKD  1
`define DDC_T_FAULT  2
`define DDC_T_READY  3
`define DDC_T_TRK0   4
`define DDC_T_TMO    5
`define DDC_T_REF    6
`define DDC_T_WRACT  7
`define DDC_T_SCOMP  8

// reset values
`define DDC_RST_CTRL  8'h00
`define DDC_RST_SEEK  17'h00000
`define DDC_RST_RWC   16'hffff
`define DDC_RST_RETRY 8'h05

// timing, figures in ns and derived cycle counts (least times round up)
`define DDC_CLK_MHZ     100
`define DDC_STEP_SU_NS  1000
`define DDC_STEP_PW_NS  1000
`define DDC_STEP_GAP_NS 10000
`define DDC_POR_NS      10000
`define DDC_CYC(ns) (((ns)*`DDC_CLK_MHZ+999)/1000)
`define DDC_STEP_SU_CYC  `DDC_CYC(`DDC_STEP_SU_NS)
`define DDC_STEP_PW_CYC  `DDC_CYC(`DDC_STEP_PW_NS)
`define DDC_STEP_GAP_CYC `DDC_CYC(`DDC_STEP_GAP_NS)
`define DDC_POR_CYC      `DDC_CYC(`DDC_POR_NS)

`endif

// file: ddc_step.v
// step pulse generator: one active-low pulse per cylinder to move
// assumes start is a one-cycle pulse seen only while busy is low
`timescale 1ns/1ps
`include "ddc_map.vh"

module ddc_step (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // request
  input  wire        start,
  input  wire [15:0] count,
  input  wire        dir_in,
  input  wire        abort,
  // drive pins and status
  output reg         step_n,
  output reg         dir_n,
  output reg         busy,
  output reg         tick
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SU   = 4'b0010;
  localparam [3:0] ST_PW   = 4'b0100;
  localparam [3:0] ST_GAP  = 4'b1000;
  localparam [15:0] SU_CYC  = `DDC_STEP_SU_CYC - 1;
  localparam [15:0] PW_CYC  = `DDC_STEP_PW_CYC - 1;
  localparam [15:0] GAP_CYC = `DDC_STEP_GAP_CYC - 1;

  reg [3:0]  state_ff;  // one-hot state
  reg [15:0] tmr_ff;    // phase timer
  reg [15:0] rem_ff;    // steps still to issue

  ////////////////////////////////////////////////////////////////////////
  // sequencer: direction set, setup time, pulse, gap, repeat
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      tmr_ff   <= 16'h0000;
      rem_ff   <= 16'h0000;
      step_n   <= 1'b1;
      dir_n    <= 1'b1;
      busy     <= 1'b0;
      tick     <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (abort && !state_ff[2])
      begin
        // stop; during a pulse, abort is taken only in the pulse's last cycle
        state_ff <= ST_IDLE;
        step_n   <= 1'b1;
        busy     <= 1'b0;
      end
      else
      begin
        case (state_ff)
          ST_IDLE:
          begin
            if (start && count != 16'h0000)
            begin
              dir_n    <= ~dir_in;
              rem_ff   <= count;
              tmr_ff   <= SU_CYC;
              busy     <= 1'b1;
              state_ff <= ST_SU;
            end
          end
          ST_SU:
          begin
            if (tmr_ff == 16'h0000)
            begin
              step_n   <= 1'b0;
              tmr_ff   <= PW_CYC;
              state_ff <= ST_PW;
            end
            else
              tmr_ff <= tmr_ff - 16'h0001;
          end
          ST_PW:
          begin
            if (tmr_ff == 16'h0000)
            begin
              step_n <= 1'b1;
              tick   <= 1'b1;
              rem_ff <= rem_ff - 16'h0001;
              if (rem_ff == 16'h0001 || abort)
              begin
                busy     <= 1'b0;
                state_ff <= ST_IDLE;
              end
              else
              begin
                tmr_ff   <= GAP_CYC;
                state_ff <= ST_GAP;
              end
            end
            else
              tmr_ff <= tmr_ff - 16'h0001;
          end
          ST_GAP:
          begin
            if (tmr_ff == 16'h0000)
            begin
              step_n   <= 1'b0;
              tmr_ff   <= PW_CYC;
              state_ff <= ST_PW;
            end
            else
              tmr_ff <= tmr_ff - 16'h0001;
          end
          default:
            state_ff <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// file: ddc_idx.v
// index pulse edge detector and revolution counter for retry timeout
// assumes index_n is synchronous to clock and active low
`timescale 1ns/1ps
`include "ddc_map.vh"

module ddc_idx (
  // clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // drive pin
  input  wire       index_n,
  // control
  input  wire       arm,
  input  wire [7:0] limit,
  // events
  output reg        idx_edge,
  output reg        timeout
);

  reg       idx_q_ff;  // last sampled index level
  reg [7:0] rev_ff;    // revolutions seen while armed
  wire      fall;      // start of an index pulse

  assign fall = idx_q_ff & ~index_n;

  ////////////////////////////////////////////////////////////////////////
  // edge pulse and bounded revolution count
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_q_ff <= 1'b1;
      rev_ff   <= 8'h00;
      idx_edge <= 1'b0;
      timeout  <= 1'b0;
    end
    else
    begin
      idx_q_ff <= index_n;
      idx_edge <= fall;
      timeout  <= 1'b0;
      if (!arm)
        rev_ff <= 8'h00;
      else if (fall)
      begin
        if (rev_ff + 8'h01 >= limit)
        begin
          timeout <= 1'b1;
          rev_ff  <= 8'h00;
        end
        else
          rev_ff <= rev_ff + 8'h01;
      end
    end
  end

endmodule

// file: ddc_top.v
// hard disk control port: head select, write gate, drive select, stepping
// assumes an apb master on the register side and drives with active-low pins
`timescale 1ns/1ps
`include "ddc_map.vh"

module ddc_top (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // drive control outputs, active low
  output reg         head_sel_bit0_n,
  output reg         head_sel_bit1_n,
  output reg         head_sel_bit2_n,
  output reg         head_sel_bit3_n,
  output reg         write_gate_n,
  output reg         drive_select_a_n,
  output reg         drive_select_b_n,
  output wire        step_n,
  output wire        step_direction_in_n,
  // drive status inputs, active low
  input  wire        seek_complete_n,
  input  wire        track_zero_n,
  input  wire        write_fault_n,
  input  wire        index_n,
  input  wire        drive_ready_n
);

  ////////////////////////////////////////////////////////////////////////
  // states and constants
  localparam [3:0]  ST_IDLE = 4'b0001;
  localparam [3:0]  ST_SEEK = 4'b0010;
  localparam [3:0]  ST_SYNC = 4'b0100;
  localparam [3:0]  ST_WR   = 4'b1000;
  localparam [15:0] POR_CYC = `DDC_POR_CYC;

  // register address match
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // storage
  reg  [7:0]  ctrl_ff;    // drive, select enable, head mode, format, head
  reg  [16:0] seek_ff;    // step count and direction
  reg  [15:0] rwc_ff;     // first inner cylinder for reduced current
  reg  [7:0]  retry_ff;   // revolutions before timeout
  reg  [15:0] cyl_ff;     // current cylinder estimate
  reg  [3:0]  state_ff;   // one-hot command state
  reg         seekd_ff;   // sticky: seek done
  reg         tmo_ff;     // sticky: retry timeout
  reg         ref_ff;     // sticky: command refused or cut by fault
  reg  [15:0] por_ff;     // power-on hold counter
  reg         init_ff;    // power-on hold over
  reg  [3:0]  nxt_state;  // next command state
  reg  [31:0] rd_mux;     // read data select
  reg         rd_ok;      // address is mapped

  // decoded bus and pin levels
  wire        wr_acc;
  wire        cmd_wr;
  wire        fault;
  wire        ready;
  wire        scomp;
  wire        trk0;
  wire        stp_busy;
  wire        stp_tick;
  wire        idx_edge;
  wire        idx_tmo;
  wire        do_seek;
  wire        do_wron;
  wire        do_wroff;
  wire        do_abort;
  wire        kill;
  wire        rwc_on;

  assign fault    = ~write_fault_n;
  assign ready    = ~drive_ready_n;
  assign scomp    = ~seek_complete_n;
  assign trk0     = ~track_zero_n;
  assign wr_acc   = psel & penable & pready & pwrite;
  assign cmd_wr   = wr_acc & hit(paddr, `DDC_A_CMD);
  assign do_seek  = cmd_wr & pwdata[`DDC_K_SEEK];
  assign do_wron  = cmd_wr & pwdata[`DDC_K_WRON];
  assign do_wroff = cmd_wr & pwdata[`DDC_K_WROFF];
  assign do_abort = cmd_wr & pwdata[`DDC_K_ABORT];
  // a seek or an index wait ends on fault, abort or timeout; a write ends on fault, abort or write off
  assign kill     = fault | do_abort | idx_tmo;
  assign rwc_on   = ctrl_ff[`DDC_C_HD8] & (cyl_ff >= rwc_ff);

  ////////////////////////////////////////////////////////////////////////
  // step generator and index counter
  ddc_step u_step (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (state_ff[0] & do_seek & ~fault & init_ff),
    .count  (seek_ff[`DDC_S_CNT]),
    .dir_in (seek_ff[`DDC_S_DIR]),
    .abort  (kill),
    .step_n (step_n),
    .dir_n  (step_direction_in_n),
    .busy   (stp_busy),
    .tick   (stp_tick)
  );

  ddc_idx u_idx (
    .clock    (clock),
    .rst_n    (rst_n),
    .index_n  (index_n),
    .arm      (state_ff[1] | state_ff[2]),
    .limit    (retry_ff),
    .idx_edge (idx_edge),
    .timeout  (idx_tmo)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb handshake: pready in first access cycle, read data registered
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    if (hit(paddr, `DDC_A_CTRL))
      rd_mux[7:0] = ctrl_ff;
    else if (hit(paddr, `DDC_A_CMD))
      rd_mux = 32'h00000000;  // write only
    else if (hit(paddr, `DDC_A_SEEK))
      rd_mux[16:0] = seek_ff;
    else if (hit(paddr, `DDC_A_RWC))
      rd_mux[15:0] = rwc_ff;
    else if (hit(paddr, `DDC_A_RETRY))
      rd_mux[7:0] = retry_ff;
    else if (hit(paddr, `DDC_A_STAT))
    begin
      rd_mux[`DDC_T_BUSY]  = ~state_ff[0];
      rd_mux[`DDC_T_SEEKD] = seekd_ff;
      rd_mux[`DDC_T_FAULT] = fault;
      rd_mux[`DDC_T_READY] = ready;
      rd_mux[`DDC_T_TRK0]  = trk0;
      rd_mux[`DDC_T_TMO]   = tmo_ff;
      rd_mux[`DDC_T_REF]   = ref_ff;
      rd_mux[`DDC_T_WRACT] = ~write_gate_n;
      rd_mux[`DDC_T_SCOMP] = scomp;
    end
    else if (hit(paddr, `DDC_A_CYL))
      rd_mux[15:0] = cyl_ff;
    else
      rd_ok = 1'b0;  // unmapped
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~rd_ok;
      if (psel & ~penable & ~pwrite)
        prdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff  <= `DDC_RST_CTRL;
      seek_ff  <= `DDC_RST_SEEK;
      rwc_ff   <= `DDC_RST_RWC;
      retry_ff <= `DDC_RST_RETRY;
    end
    else if (wr_acc)
    begin
      if (hit(paddr, `DDC_A_CTRL))
        ctrl_ff <= pwdata[7:0];
      if (hit(paddr, `DDC_A_SEEK))
        seek_ff <= pwdata[16:0];
      if (hit(paddr, `DDC_A_RWC))
        rwc_ff <= pwdata[15:0];
      if (hit(paddr, `DDC_A_RETRY))
        retry_ff <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-on hold: no write gate until the counter runs out
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_ff  <= 16'h0000;
      init_ff <= 1'b0;
    end
    else if (!init_ff)
    begin
      por_ff  <= por_ff + 16'h0001;
      init_ff <= (por_ff == POR_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command state machine
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (do_seek & ~fault & init_ff)
          nxt_state = ST_SEEK;
        else if (do_wron & ~fault & init_ff & ready & scomp)
          nxt_state = ctrl_ff[`DDC_C_FMT] ? ST_SYNC : ST_WR;
      end
      ST_SEEK:
      begin
        if (kill)
          nxt_state = ST_IDLE;
        else if (~stp_busy & scomp)
          nxt_state = ST_IDLE;
      end
      ST_SYNC:
      begin
        if (kill)
          nxt_state = ST_IDLE;
        else if (idx_edge)
          nxt_state = ST_WR;
      end
      ST_WR:
      begin
        if (fault | do_abort | do_wroff)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status; a hardware set wins over a same-cycle clear
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seekd_ff <= 1'b0;
      tmo_ff   <= 1'b0;
      ref_ff   <= 1'b0;
    end
    else
    begin
      if (state_ff[1] & ~kill & ~stp_busy & scomp)
        seekd_ff <= 1'b1;
      else if (wr_acc & hit(paddr, `DDC_A_STAT) & pwdata[`DDC_T_SEEKD])
        seekd_ff <= 1'b0;
      if (idx_tmo & (state_ff[1] | state_ff[2]))
        tmo_ff <= 1'b1;
      else if (wr_acc & hit(paddr, `DDC_A_STAT) & pwdata[`DDC_T_TMO])
        tmo_ff <= 1'b0;
      // refused while faulted, or active command cut by fault
      if (((do_seek | do_wron) & fault) | (fault & ~state_ff[0]))
        ref_ff <= 1'b1;
      else if (wr_acc & hit(paddr, `DDC_A_STAT) & pwdata[`DDC_T_REF])
        ref_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cylinder tracking from issued steps and track zero
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cyl_ff <= 16'h0000;
    else if (stp_tick)
    begin
      if (~step_direction_in_n)
        cyl_ff <= cyl_ff + 16'h0001;
      else if (cyl_ff != 16'h0000)
        cyl_ff <= cyl_ff - 16'h0001;
    end
    else if (trk0 & ~stp_busy)
      cyl_ff <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // drive pins: write gate, selects, head lines
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_gate_n     <= 1'b1;
      drive_select_a_n <= 1'b1;
      drive_select_b_n <= 1'b1;
      head_sel_bit0_n  <= 1'b1;
      head_sel_bit1_n  <= 1'b1;
      head_sel_bit2_n  <= 1'b1;
      head_sel_bit3_n  <= 1'b1;
    end
    else
    begin
      // only while writing, released at once on fault
      write_gate_n <= ~(nxt_state[3] & init_ff & ~fault);
      // select lines decoded from the drive and select enable bits, never both low
      drive_select_a_n <= ~(ctrl_ff[`DDC_C_SELEN] & ~ctrl_ff[`DDC_C_DRV]);
      drive_select_b_n <= ~(ctrl_ff[`DDC_C_SELEN] & ctrl_ff[`DDC_C_DRV]);
      if (!stp_busy)
      begin
        // head lines change only while the step generator is not busy
        head_sel_bit0_n <= ~ctrl_ff[4];
        head_sel_bit1_n <= ~ctrl_ff[5];
        head_sel_bit2_n <= ~ctrl_ff[6];
        if (ctrl_ff[`DDC_C_HD8])
          head_sel_bit3_n <= ~rwc_on;
        else
          head_sel_bit3_n <= ~ctrl_ff[`DDC_C_HMSB];
      end
    end
  end

endmodule

// file: ddc_checker.sv
// pin checker for the drive control port
// assumes it is bound to ddc_top and sees only its ports
`timescale 1ns/1ps
module ddc_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // drive control pins
  input wire logic head_sel_bit0_n,
  input wire logic head_sel_bit1_n,
  input wire logic head_sel_bit2_n,
  input wire logic head_sel_bit3_n,
  input wire logic write_gate_n,
  input wire logic drive_select_a_n,
  input wire logic drive_select_b_n,
  input wire logic step_n,
  input wire logic step_direction_in_n,
  // drive status pins
  input wire logic seek_complete_n,
  input wire logic write_fault_n,
  input wire logic drive_ready_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  logic [10:0] por_ff; // cycles since reset release, saturating
  logic [7:0]  low_ff; // cycles the step line has stayed low
  // power-on age and step pulse width
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_ff <= 11'h000;
      low_ff <= 8'h00;
    end
    else
    begin
      por_ff <= (por_ff == 11'h7ff) ? por_ff : por_ff + 11'h001;
      low_ff <= step_n ? 8'h00 : low_ff + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////
  sel_one_a: assert property (drive_select_a_n || drive_select_b_n)
    else $error("two selects");
  por_gate_a: assert property (por_ff < 11'h3e8 |-> write_gate_n)
    else $error("gate in power-on");
  fault_gate_a: assert property (!write_fault_n |=> write_gate_n)
    else $error("gate on fault");
  gate_cause_a: assert property ($fell(write_gate_n) |->
    !$past(drive_ready_n) && !$past(seek_complete_n))
    else $error("gate not ready");
  step_width_a: assert property ($rose(step_n) |-> low_ff == 8'h64)
    else $error("step width");
  dir_lead_a: assert property ($fell(step_n) |->
    step_direction_in_n == $past(step_direction_in_n, 90))
    else $error("dir lead");
  dir_hold_a: assert property (!step_n |-> $stable(step_direction_in_n))
    else $error("dir moved");
  head_hold_a: assert property (!step_n && !$past(step_n) |->
    $stable({head_sel_bit3_n, head_sel_bit2_n, head_sel_bit1_n, head_sel_bit0_n}))
    else $error("heads moved");
endmodule

bind ddc_top ddc_checker u_chk (
  .clock(clock), .rst_n(rst_n), .head_sel_bit0_n(head_sel_bit0_n),
  .head_sel_bit1_n(head_sel_bit1_n), .head_sel_bit2_n(head_sel_bit2_n),
  .head_sel_bit3_n(head_sel_bit3_n), .write_gate_n(write_gate_n),
  .drive_select_a_n(drive_select_a_n), .drive_select_b_n(drive_select_b_n),
  .step_n(step_n), .step_direction_in_n(step_direction_in_n),
  .seek_complete_n(seek_complete_n), .write_fault_n(write_fault_n),
  .drive_ready_n(drive_ready_n)
);

// file: ddc_drive_model.sv
// behavioural disk drive on the daisy chain, answering on select a
// assumes the port samples status on the same clock
`timescale 1ns/1ps
module ddc_drive_model #(
  parameter int REV    = 2000, // cycles per revolution, shortened
  parameter int SPIN   = 300,  // cycles to reach speed
  parameter int SETTLE = 50    // cycles to settle after a step
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // control pins from the port
  input  wire logic sel_n,
  input  wire logic step_n,
  input  wire logic dir_n,
  // fault demand
  input  wire logic fault_req,
  // status pins, high when deselected
  output wire logic seek_complete_n,
  output wire logic track_zero_n,
  output wire logic write_fault_n,
  output wire logic index_n,
  output wire logic drive_ready_n,
  // head position
  output int        cyl
);
  int   rev_ff;    // place within one revolution
  int   spin_ff;   // spin-up progress
  int   settle_ff; // cycles since the last step
  logic step_q;    // step line one cycle ago
  // spindle, positioner and settle timers
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rev_ff <= 0;
      spin_ff <= 0;
      settle_ff <= 0;
      cyl <= 0;
      step_q <= 1'b1;
    end
    else
    begin
      rev_ff <= (rev_ff == REV - 1) ? 0 : rev_ff + 1;
      spin_ff <= (spin_ff < SPIN) ? spin_ff + 1 : spin_ff;
      settle_ff <= !step_n ? 0 : (settle_ff < SETTLE) ? settle_ff + 1 : settle_ff;
      step_q <= step_n;
      // one cylinder per leading edge, low dir inward
      if (!sel_n && step_q && !step_n)
        cyl <= dir_n ? ((cyl > 0) ? cyl - 1 : 0) : cyl + 1;
    end
  end
  // status lines, asserted low only while selected
  assign drive_ready_n   = sel_n | (spin_ff < SPIN);
  assign seek_complete_n = sel_n | (settle_ff < SETTLE);
  assign track_zero_n    = sel_n | (cyl != 0);
  assign index_n         = sel_n | (rev_ff >= 4);
  assign write_fault_n   = sel_n | !fault_req;
endmodule

// file: disk_drive_control_port_test.sv
// self-checking bench for the drive control port with one drive model
// assumes the register map header and a drive answering on select a
`timescale 1ns/1ps
`include "ddc_map.vh"
module disk_drive_control_port_test;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable;   // apb phase
  logic        pwrite;          // apb direction
  logic [7:0]  paddr;           // apb address
  logic [31:0] pwdata, prdata;  // apb data
  logic        pready, pslverr; // apb answer
  logic [3:0]  hs_n;            // head lines
  logic        wg_n, dsa_n;     // write gate, select a
  logic        dsb_n, stp_n;    // select b, step
  logic        dir_n, sc_n;     // direction, seek complete
  logic        tz_n, wf_n;      // track zero, write fault
  logic        idx_n, rdy_n;    // index, ready
  logic        fault_req = 1'b0;
  int          cyl_m;           // position seen by the drive
  logic [31:0] rq;              // last read data
  logic        rerr;            // last slave error
  logic [31:0] seed = 32'ha877; // xorshift state
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          n_steps = 0;
  always #5 clock = ~clock;
  always @(negedge stp_n) n_steps++;
  ////////////////////////////////////////////////////////////////
  ddc_top i_dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .head_sel_bit0_n(hs_n[0]), .head_sel_bit1_n(hs_n[1]), .head_sel_bit2_n(hs_n[2]),
    .head_sel_bit3_n(hs_n[3]), .write_gate_n(wg_n), .drive_select_a_n(dsa_n),
    .drive_select_b_n(dsb_n), .step_n(stp_n), .step_direction_in_n(dir_n),
    .seek_complete_n(sc_n), .track_zero_n(tz_n), .write_fault_n(wf_n),
    .index_n(idx_n), .drive_ready_n(rdy_n));
  ddc_drive_model i_drv (
    .clock(clock), .rst_n(rst_n), .sel_n(dsa_n), .step_n(stp_n), .dir_n(dir_n),
    .fault_req(fault_req), .seek_complete_n(sc_n), .track_zero_n(tz_n),
    .write_fault_n(wf_n), .index_n(idx_n), .drive_ready_n(rdy_n), .cyl(cyl_m));
  ////////////////////////////////////////////////////////////////
  // xorshift source
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected head pins; bit 3 msb or rwc flag
  function logic [3:0] exp_heads(input logic [3:0] h, input logic hd8, input logic red);
    return ~{hd8 ? red : h[3], h[2:0]};
  endfunction
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp, input string m);
    chk_word({31'h0, got}, {31'h0, exp}, m);
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      close_out();
    end
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // wait edges, then settle
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // poll busy with a bound
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `DDC_A_STAT, 32'h0);
      n++;
    end
    while (rq[`DDC_T_BUSY] !== 1'b0 && n < 3000);
    if (n >= 3000)
    begin
      n_mismatch++;
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0]  ra [4];
    logic [31:0] rv [4];
    logic [3:0]  h;
    logic [15:0] cnt;
    int          n;
    int          since;
    logic        iq;
    ra = '{`DDC_A_CTRL, `DDC_A_SEEK, `DDC_A_RWC, `DDC_A_RETRY};
    rv = '{32'h0, 32'h0, 32'hffff, 32'h5};
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    idle(3);
    chk_word({hs_n, wg_n, dsa_n, dsb_n, stp_n, dir_n}, 32'h1ff, "pins in reset");
    idle(3);
    rst_n <= 1'b1;
    // reset values, unmapped place
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk_word(rq, rv[i], "reset");
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk_pin(rerr, 1'b1, "unmapped");
    idle(1100);
    // selects: drive 0, drive 1, none
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, `DDC_A_CTRL, (i == 2) ? 32'h0 : 32'h2 + i);
      idle(2);
      chk_word({dsb_n, dsa_n}, (i == 2) ? 32'h3 : (i ? 32'h1 : 32'h2), "select");
    end
    // random heads in sixteen-head mode
    for (int i = 0; i < 6; i++)
    begin
      h = rnd();
      apb(1'b1, `DDC_A_CTRL, {h, 4'h2});
      idle(2);
      chk_word(hs_n, exp_heads(h, 1'b0, 1'b0), "heads");
    end
    // seek in, then out to track zero
    cnt = 16'h1 + (rnd() & 16'h3);
    for (int k = 0; k < 2; k++)
    begin
      n_steps = 0;
      apb(1'b1, `DDC_A_SEEK, {15'h0, k == 0, cnt});
      apb(1'b1, `DDC_A_CMD, 32'h1);
      wait_idle();
      chk_word(n_steps, cnt, "steps");
      chk_pin(dir_n, k, "direction");
      chk_word(cyl_m, k ? 0 : cnt, "position");
      chk_word(rq & 32'h12, k ? 32'h12 : 32'h2, "seek status");
      apb(1'b1, `DDC_A_STAT, 32'h62);
    end
    // eight-head mode: fourth line is reduced current
    for (int r = 0; r < 2; r++)
    begin
      h = rnd() | 4'h8;
      apb(1'b1, `DDC_A_RWC, r);
      apb(1'b1, `DDC_A_CTRL, {h, 4'h6});
      idle(2);
      chk_word(hs_n, exp_heads(h, 1'b1, r == 0), "rwc");
    end
    // write gate, fault, refusal, recovery
    apb(1'b1, `DDC_A_CTRL, 32'h2);
    apb(1'b1, `DDC_A_CMD, 32'h2);
    idle(3);
    chk_pin(wg_n, 1'b0, "gate on");
    @(posedge clock) fault_req <= 1'b1;
    idle(3);
    chk_pin(wg_n, 1'b1, "fault gate");
    apb(1'b1, `DDC_A_CMD, 32'h2);
    apb(1'b0, `DDC_A_STAT, 32'h0);
    chk_word(rq & 32'hc4, 32'h44, "refusal");
    @(posedge clock) fault_req <= 1'b0;
    idle(3);
    apb(1'b1, `DDC_A_STAT, 32'h62);
    apb(1'b1, `DDC_A_CMD, 32'h2);
    idle(3);
    chk_pin(wg_n, 1'b0, "regate");
    apb(1'b1, `DDC_A_CMD, 32'h4);
    idle(3);
    chk_pin(wg_n, 1'b1, "gate off");
    // format write waits for index
    apb(1'b1, `DDC_A_CTRL, 32'ha);
    apb(1'b1, `DDC_A_CMD, 32'h2);
    n = 0;
    since = 99;
    iq = 1'b1;
    while (wg_n !== 1'b0 && n < 5000)
    begin
      idle(1);
      since = (iq && !idx_n) ? 0 : since + 1;
      iq = idx_n;
      n++;
    end
    chk_pin(since < 5 && n < 5000, 1'b1, "format");
    apb(1'b1, `DDC_A_CMD, 32'h4);
    // long seek cut by revolution count
    apb(1'b1, `DDC_A_CTRL, 32'h2);
    apb(1'b1, `DDC_A_RETRY, 32'h2);
    apb(1'b1, `DDC_A_SEEK, 32'h1003c);
    n_steps = 0;
    apb(1'b1, `DDC_A_CMD, 32'h1);
    wait_idle();
    chk_pin(rq[`DDC_T_TMO], 1'b1, "timeout");
    chk_pin(n_steps <= 6, 1'b1, "cut");
    close_out();
  end
endmodule
